// File: verilog/pin_mux_pkg.sv
`default_nettype none

package pin_mux_pkg;

  // ****************************************
  // mode configuration
  // ****************************************
  localparam logic [2:0] MODE_DPI_SPI = 3'h3;
  localparam logic [2:0] MODE_DPI_SSI = 3'h4;
  localparam logic [2:0] MODE_DBI     = 3'h5;

  // ****************************************
  // register map (word addresses)
  // ****************************************
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_GP_OUT  = 4'h1;
  localparam logic [3:0] ADDR_GP_OE   = 4'h2;
  localparam logic [3:0] ADDR_GP_IN   = 4'h3;
  localparam logic [3:0] ADDR_DRIVE   = 4'h4;
  localparam logic [3:0] ADDR_PULL    = 4'h5;
  localparam logic [3:0] ADDR_STATUS  = 4'h6;

  // control register field positions
  localparam int CTRL_WIDTH_SEL = 0;
  localparam int CTRL_FSEL10    = 1;
  localparam int CTRL_FSEL11    = 2;
  localparam int CTRL_FSEL12    = 3;

  // values after reset
  localparam logic [3:0]  CTRL_RST   = 4'h1;
  localparam logic [5:0]  GP_RST     = 6'h00;
  localparam logic [1:0]  DRIVE_RST  = 2'h0;
  localparam logic [1:0]  PULL_RST   = 2'h0;

  // drive codes: 0=1mA 1=2mA 2=3mA 3=4mA
  localparam logic [1:0]  DRIVE_SMT  = 2'h1;

  // widths
  localparam int VDW = 24;
  localparam int GPW = 6;

  // pull option of a schmitt pad
  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } pull_s;

  // host interface strobes after the mux
  typedef struct packed {
    logic vsync;
    logic hsync;
    logic de;
    logic pclk;
  } dpi_s;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic dc_n;
    logic wr_n;
  } dbi_s;

  typedef enum logic [1:0] {
    HOST_NONE,
    HOST_DPI,
    HOST_DBI
  } host_mode_e;

endpackage : pin_mux_pkg

`default_nettype wire

// File: verilog/gp_pin_cell.sv
`timescale 1ns/1ns
`default_nettype none

// one pad slot of the upper data bus: data, alternate function or gpio
module gp_pin_cell
  import pin_mux_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic wide_i,
  input  wire logic alt_sel_i,
  input  wire logic alt_val_i,
  input  wire logic has_alt_i,
  input  wire logic gp_out_i,
  input  wire logic gp_oe_i,
  input  wire logic pad_in_i,
  output logic      data_o,
  output logic      gp_in_o,
  output logic      pad_out_o,
  output logic      pad_oe_o
);

  // ****************************************
  // output selection
  // ****************************************
  always_comb begin
    if (wide_i) begin
      pad_out_o = 1'b0;
      pad_oe_o  = 1'b0;
    end else if (has_alt_i && alt_sel_i) begin
      pad_out_o = alt_val_i;
      pad_oe_o  = 1'b1;
    end else begin
      pad_out_o = gp_out_i;
      pad_oe_o  = gp_oe_i;
    end
  end

  // ****************************************
  // registered inputs
  // ****************************************
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_o  <= 1'b0;
      gp_in_o <= 1'b0;
    end else begin
      data_o  <= wide_i ? pad_in_i : 1'b0;
      gp_in_o <= wide_i ? 1'b0 : pad_in_i;
    end
  end

endmodule : gp_pin_cell

`default_nettype wire

// File: verilog/display_bridge_host_pin_mux.sv
// Functional notes
// R1: standby low floats all pins but pin six
// R2: device held in reset while reset low
// R3: standby low enters standby, high operates
// R4: config, reset, clock, standby pins plain inputs
// R5: three config pins pick host interface
// R6: 011/100 pixel, 101 parallel, others reserved
// R7: vsync pin becomes chip select in parallel
// R8: hsync pin becomes read strobe in parallel
// R9: enable pin becomes data/command in parallel
// R10: pixel clock pin becomes write strobe
// R11: bus width 8/16/18/24, host drives selected
// R12: narrow width turns pins 18-20 into gpio
// R13: pin 21 interrupt or gpio ten
// R14: pin 22 pwm or gpio eleven
// R15: pin 23 clock output or gpio twelve
// R16: cmos pads drive 1 to 4 mA
// R17: schmitt pads pull control, fixed 2 mA
// R18: pin 23 has its own select bit
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module display_bridge_host_pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             system_reset_n_i,
  input  wire logic             standby_request_n_i,
  input  wire logic [2:0]       mode_config_pins_i,
  // register port
  input  wire logic [3:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  // host sync / strobe pins
  input  wire logic             vsync_pin_i,
  input  wire logic             hsync_pin_i,
  input  wire logic             de_pin_i,
  input  wire logic             pclk_pin_i,
  // video data bus pads
  input  wire logic [VDW-1:0]   video_data_bus_i,
  output logic      [VDW-1:0]   video_data_bus_o,
  output logic      [VDW-1:0]   video_data_bus_oe_o,
  // general pin six pad
  input  wire logic             general_pin_six_i,
  output logic                  general_pin_six_pd_o,
  // alternate function sources
  input  wire logic             irq_src_i,
  input  wire logic             pwm_src_i,
  input  wire logic             clock_output_src_i,
  // decoded host side
  output host_mode_e            host_mode_o,
  output dpi_s                  dpi_o,
  output dbi_s                  dbi_o,
  output logic      [VDW-1:0]   video_data_o,
  output logic                  core_reset_o,
  output logic                  standby_o,
  // pad electrical controls
  output logic      [1:0]       cmos_drive_o,
  output logic      [1:0]       schmitt_pad_drive_o,
  output pull_s                 schmitt_pad_pull_o,
  output logic                  input_pull_en_o
);

  // ****************************************
  // registers
  // ****************************************
  // software settings, pin state and the internal wires of the
  // six upper pad slots
  logic [3:0]     ctrl_r;
  logic [GPW-1:0] gp_out_r;
  logic [GPW-1:0] gp_oe_r;
  logic [1:0]     drive_r;
  logic [1:0]     pull_r;
  logic [2:0]     mode_r;
  host_mode_e     host_mode_r;
  logic           core_rst_r;
  logic           standby_request_n_r;
  logic [GPW-1:0] gp_in_w;
  logic [GPW-1:0] cell_out_w;
  logic [GPW-1:0] cell_oe_w;
  logic [GPW-1:0] cell_data_w;
  logic [17:0]    low_data_r;

  // ****************************************
  // reset and standby state
  // ****************************************
  // both pins are taken as synchronous; one flop each keeps their
  // effect aligned with the rest of the registered logic, and both
  // come up asserted so nothing drives before the first edge
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_rst_r <= 1'b1;
      standby_request_n_r     <= 1'b1;
    end else begin
      core_rst_r <= ~system_reset_n_i; // R2
      standby_request_n_r     <= ~standby_request_n_i; // R3
    end
  end

  // status levels for the core and the pad ring
  assign core_reset_o = core_rst_r;
  assign standby_o    = standby_request_n_r;

  // ****************************************
  // mode capture
  // ****************************************
  // config pins are sampled while the core reset is active
  // the last value seen before release sticks, so straps may
  // settle during reset without glitching the host mode
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_r <= 3'h0;
    end else if (core_rst_r) begin
      mode_r <= mode_config_pins_i; // R5
    end
  end

  // decode one cycle after capture; reserved straps idle the pins
  // so a test mode never reaches the host side
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_mode_r <= HOST_NONE;
    end else begin
      case (mode_r)
        MODE_DPI_SPI: host_mode_r <= HOST_DPI; // R6
        MODE_DPI_SSI: host_mode_r <= HOST_DPI; // R6
        MODE_DBI:     host_mode_r <= HOST_DBI; // R6
        default:      host_mode_r <= HOST_NONE; // R6
      endcase
    end
  end

  // decoded mode for the core
  assign host_mode_o = host_mode_r;

  // ****************************************
  // register writes
  // ****************************************
  // core reset clears every setting and blocks software writes,
  // so a write issued while the core is held has no effect;
  // unmapped and read-only offsets are ignored
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r   <= CTRL_RST;
      gp_out_r <= GP_RST;
      gp_oe_r  <= GP_RST;
      drive_r  <= DRIVE_RST;
      pull_r   <= PULL_RST;
    end else if (core_rst_r) begin
      ctrl_r   <= CTRL_RST;
      gp_out_r <= GP_RST;
      gp_oe_r  <= GP_RST;
      drive_r  <= DRIVE_RST;
      pull_r   <= PULL_RST;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_CTRL:   ctrl_r   <= wdata_i[3:0]; // R18
        ADDR_GP_OUT: gp_out_r <= wdata_i[GPW-1:0];
        ADDR_GP_OE:  gp_oe_r  <= wdata_i[GPW-1:0];
        ADDR_DRIVE:  drive_r  <= wdata_i[1:0]; // R16
        ADDR_PULL:   pull_r   <= wdata_i[1:0]; // R17
        default:     ctrl_r   <= ctrl_r;
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // read data stand for one cycle after the strobe, then return
  // to zero so a stale word is never mistaken for a fresh one
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CTRL:   rdata_o <= {28'h0, ctrl_r};
        ADDR_GP_OUT: rdata_o <= {26'h0, gp_out_r};
        ADDR_GP_OE:  rdata_o <= {26'h0, gp_oe_r};
        ADDR_GP_IN:  rdata_o <= {26'h0, gp_in_w};
        ADDR_DRIVE:  rdata_o <= {30'h0, drive_r};
        ADDR_PULL:   rdata_o <= {30'h0, pull_r};
        ADDR_STATUS: rdata_o <= {25'h0, standby_request_n_r, core_rst_r, host_mode_r, mode_r};
        default:     rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // ****************************************
  // sync and strobe pin meaning
  // ****************************************
  // one flop stage per pin: parallel strobes rest high and pixel
  // syncs rest low whenever no host mode is live, so the core
  // never sees a false edge while the bridge sleeps
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dpi_o <= '0;
      dbi_o <= '1;
    end else if (host_mode_r == HOST_DBI && !standby_request_n_r) begin
      dpi_o <= '0;
      dbi_o.cs_n <= vsync_pin_i; // R7
      dbi_o.rd_n <= hsync_pin_i; // R8
      dbi_o.dc_n <= de_pin_i; // R9
      dbi_o.wr_n <= pclk_pin_i; // R10
    end else if (host_mode_r == HOST_DPI && !standby_request_n_r) begin
      dbi_o <= '1;
      dpi_o.vsync <= vsync_pin_i; // R7
      dpi_o.hsync <= hsync_pin_i; // R8
      dpi_o.de    <= de_pin_i; // R9
      dpi_o.pclk  <= pclk_pin_i; // R10
    end else begin
      dpi_o <= '0;
      dbi_o <= '1;
    end
  end

  // ****************************************
  // low data bits 0..17 are always data inputs
  // ****************************************
  // these lanes have no second function; lanes 18 to 23
  // come through the upper slots instead, as data only in wide mode
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_data_r <= '0;
    end else begin
      low_data_r <= video_data_bus_i[17:0]; // R11
    end
  end

  // ****************************************
  // upper six pins: data, alternate or gpio
  // ****************************************
  // slot g serves pin 18+g and gpio 7+g; slots 3 to 5 also carry
  // interrupt, pwm and clock output, each behind its own select
  // bit, so pin 23 never follows the select of pin 21
  genvar g;
  generate
    for (g = 0; g < GPW; g++) begin : g_cell
      // select and source of the alternate function of this slot
      logic has_alt;
      logic alt_sel;
      logic alt_val;
      assign has_alt = (g >= 3); // R13
      assign alt_sel = (g == 3) ? ctrl_r[CTRL_FSEL10] :
                       (g == 4) ? ctrl_r[CTRL_FSEL11] : ctrl_r[CTRL_FSEL12]; // R15
      assign alt_val = (g == 3) ? irq_src_i :
                       (g == 4) ? pwm_src_i : clock_output_src_i; // R14
      // the cell registers its pad input and picks the pad output
      gp_pin_cell u_cell (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .wide_i    (ctrl_r[CTRL_WIDTH_SEL]), // R12
        .alt_sel_i (alt_sel),
        .alt_val_i (alt_val),
        .has_alt_i (has_alt),
        .gp_out_i  (gp_out_r[g]),
        .gp_oe_i   (gp_oe_r[g]),
        .pad_in_i  (video_data_bus_i[18+g]),
        .data_o    (cell_data_w[g]),
        .gp_in_o   (gp_in_w[g]),
        .pad_out_o (cell_out_w[g]),
        .pad_oe_o  (cell_oe_w[g])
      );
    end
  endgenerate

  // full data word seen by the core
  assign video_data_o = {cell_data_w, low_data_r};

  // ****************************************
  // pad drive: everything floats in standby or reset
  // ****************************************
  // the ring stays undriven while sleeping or in core reset so the
  // host can park its bus without fighting the bridge
  always_comb begin
    video_data_bus_o    = {cell_out_w, 18'h0};
    video_data_bus_oe_o = {cell_oe_w, 18'h0};
    if (standby_request_n_r || core_rst_r) begin
      video_data_bus_o    = '0; // R1
      video_data_bus_oe_o = '0; // R1
    end
  end

  // ****************************************
  // pad electrical options
  // ****************************************
  // pin six keeps its pull-down in every state; strap, reset, clock
  // and standby inputs never get a pull; schmitt pads run a fixed
  // 2 mA drive while cmos pads follow the drive register
  assign general_pin_six_pd_o = 1'b1; // R1
  assign input_pull_en_o      = 1'b0; // R4
  assign cmos_drive_o         = drive_r; // R16
  assign schmitt_pad_drive_o  = DRIVE_SMT; // R17
  assign schmitt_pad_pull_o   = standby_request_n_r ? '0 : pull_s'(pull_r); // R17

endmodule : display_bridge_host_pin_mux

`default_nettype wire

// File: tb/host_bus_model.sv
`timescale 1ns/1ns
`default_nettype none

// host on the far side: drives strobes and all 24 lanes, inverting lanes 18 to 23 unless width_i is 3
module host_bus_model
  import pin_mux_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       dbi_i,
  input  wire logic [1:0] width_i,
  output logic [3:0]      strobe_o = 4'hF,
  output logic [VDW-1:0]  data_o = '0
);
  logic [7:0]     cnt_r = 8'h00;
  logic [VDW-1:0] lanes;

  // unused lanes carry an inverted, churning pattern
  assign lanes = width_i == 2'h3 ? 24'hFFFFFF : 24'h03FFFF;
  // parallel bus keeps chip select low and toggles write and command
  always @(posedge sys_clk_i) begin
    cnt_r <= cnt_r + 8'h01;
    strobe_o <= dbi_i ? {2'h1, cnt_r[1:0]} : cnt_r[3:0];
    data_o <= ({3{cnt_r}} & lanes) | ({3{~cnt_r}} & ~lanes);
  end
endmodule // host_bus_model

`default_nettype wire

// File: tb/display_bridge_host_pin_mux_chk.sv
`timescale 1ns/1ns
`default_nettype none

module pin_mux_chk
  import pin_mux_pkg::*;
(
  input wire logic           sys_clk_i,
  input wire logic           reset_i,
  input wire logic           system_reset_n_i,
  input wire logic           standby_request_n_i,
  input wire logic           vsync_pin_i,
  input wire logic           hsync_pin_i,
  input wire logic           de_pin_i,
  input wire logic           pclk_pin_i,
  input wire logic [VDW-1:0] video_data_bus_oe_o,
  input wire logic           general_pin_six_pd_o,
  input wire host_mode_e     host_mode_o,
  input wire dpi_s           dpi_o,
  input wire dbi_s           dbi_o,
  input wire logic           core_reset_o,
  input wire logic           standby_o,
  input wire logic           input_pull_en_o
);
  // ********
  // pin state checks
  // ********
  wire logic [3:0] hp = {vsync_pin_i, hsync_pin_i, de_pin_i, pclk_pin_i};
  wire logic       live = !standby_o && !core_reset_o;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_pin_six_pull: assert property (general_pin_six_pd_o)
    else $error("pin six pull off");
  a_standby_float: assert property (
    standby_o && !standby_request_n_i |-> video_data_bus_oe_o == '0)
    else $error("pads driven in standby");
  a_standby_enter: assert property (
    !standby_request_n_i |=> standby_o) else $error("no standby");
  a_core_float: assert property (
    core_reset_o && !system_reset_n_i |-> video_data_bus_oe_o == '0)
    else $error("pads driven in reset");
  a_core_enter: assert property (
    (!system_reset_n_i) [*2] |-> core_reset_o) else $error("no core reset");
  a_plain_inputs: assert property (!input_pull_en_o)
    else $error("input pulls on");
  a_dbi_map: assert property (
    (host_mode_o == HOST_DBI && live) [*2] |-> dbi_o == $past(hp))
    else $error("parallel strobes wrong");
  a_dpi_map: assert property (
    (host_mode_o == HOST_DPI && live) [*2] |-> dpi_o == $past(hp))
    else $error("pixel strobes wrong");

  c_dbi: cover property (host_mode_o == HOST_DBI && live);
  c_dpi: cover property (host_mode_o == HOST_DPI && live);
  c_standby: cover property (standby_o && !core_reset_o);
endmodule // pin_mux_chk

bind display_bridge_host_pin_mux pin_mux_chk u_pin_mux_chk (.*);

`default_nettype wire

// File: tb/display_bridge_host_pin_mux_tb.sv
`timescale 1ns/1ns
`default_nettype none

module display_bridge_host_pin_mux_tb
  import pin_mux_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic system_reset_n_i = 1'b1;
  logic standby_request_n_i = 1'b1;
  logic [2:0] mode_config_pins_i = MODE_DBI;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] alt = 3'h0;
  logic [1:0] host_w = 2'h3;
  logic [3:0] pins;
  logic [31:0] rdata_o;
  logic [VDW-1:0] host_data, video_data_bus_i, video_data_bus_o;
  logic [VDW-1:0] video_data_bus_oe_o, video_data_o;
  host_mode_e host_mode_o;
  dpi_s dpi_o;
  dbi_s dbi_o;
  pull_s schmitt_pad_pull_o;
  logic core_reset_o, standby_o;
  logic [1:0] cmos_drive_o, schmitt_pad_drive_o;
  int fail_count = 0;
  int comparisons = 0;
  int ticks = 0;
  logic [2:0] modes [5] = '{MODE_DPI_SPI, MODE_DPI_SSI, MODE_DBI, 3'h6, 3'h0};
  host_mode_e hms [5] = '{HOST_DPI, HOST_DPI, HOST_DBI, HOST_NONE, HOST_NONE};

  display_bridge_host_pin_mux u_display_bridge_host_pin_mux (.*, .general_pin_six_i(1'b0),
    .vsync_pin_i(pins[3]), .hsync_pin_i(pins[2]), .de_pin_i(pins[1]), .pclk_pin_i(pins[0]),
    .irq_src_i(alt[0]), .pwm_src_i(alt[1]), .clock_output_src_i(alt[2]),
    .general_pin_six_pd_o(), .input_pull_en_o());
  host_bus_model u_host_bus_model (.sys_clk_i(sys_clk_i), .width_i(host_w),
    .dbi_i(mode_config_pins_i == MODE_DBI), .strobe_o(pins), .data_o(host_data));
  // pad level: device where it drives, host elsewhere
  assign video_data_bus_i = (video_data_bus_oe_o & video_data_bus_o)
                          | (~video_data_bus_oe_o & host_data);

  initial forever #20 sys_clk_i = ~sys_clk_i;

  // ********
  // bench tasks
  // ********
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata_o, e);
    @(posedge sys_clk_i);
  endtask

  // host pins seen now must show at the outputs one edge later
  task automatic track(input host_mode_e hm);
    logic [3:0] p;
    logic [VDW-1:0] d;
    #1 p = pins;
    d = video_data_bus_i;
    @(posedge sys_clk_i);
    #1;
    if (hm == HOST_DBI) chk("dbi", dbi_o, p);
    else if (hm == HOST_DPI) chk("dpi", dpi_o, p);
    else chk("idle", dbi_o, 4'hF);
    if (hm != HOST_NONE) chk("data", video_data_o, d);
    @(posedge sys_clk_i);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk_i) begin
    ticks++;
    if (ticks == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ********
  // test sequence
  // ********
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rc(ADDR_CTRL, CTRL_RST);
    for (int a = 1; a < 6; a++) if (a != 3) rc(a[3:0], 32'h0);
    rc(4'hF, 32'h0);
    // narrow bus: upper pins become gpio or alternate outputs
    host_w <= 2'h2;
    wr(ADDR_GP_OUT, 32'h15);
    wr(ADDR_GP_OE, 32'h3F);
    alt <= 3'h5;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL, k * 2);
      #1 chk("upper", {video_data_bus_oe_o[23:18], video_data_bus_o[23:18]},
             {6'h3F, (k[2:0] & 3'h5) | (~k[2:0] & 3'h2), 3'h5});
      @(posedge sys_clk_i);
    end
    rc(ADDR_GP_IN, 32'h2D);
    standby_request_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk("standby", {standby_o, video_data_bus_oe_o}, {1'b1, 24'h0});
    @(posedge sys_clk_i);
    standby_request_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 chk("awake", {standby_o, video_data_bus_oe_o[23:18]}, 7'h3F);
    @(posedge sys_clk_i);
    wr(ADDR_CTRL, CTRL_RST);
    #1 chk("wide", video_data_bus_oe_o, 24'h0);
    @(posedge sys_clk_i);
    host_w <= 2'h3;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_DRIVE, d);
      #1 chk("drive", cmos_drive_o, d[1:0]);
      @(posedge sys_clk_i);
    end
    wr(ADDR_PULL, 32'h2);
    #1 chk("pull", schmitt_pad_pull_o, 2'h2);
    chk("smt drive", schmitt_pad_drive_o, DRIVE_SMT);
    @(posedge sys_clk_i);
    // each mode through a core reset, with a write that must be ignored
    for (int m = 0; m < 5; m++) begin
      system_reset_n_i <= 1'b0;
      mode_config_pins_i <= modes[m];
      repeat (2) @(posedge sys_clk_i);
      wr(ADDR_DRIVE, 32'h3);
      system_reset_n_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rc(ADDR_DRIVE, 32'h0);
      rc(ADDR_STATUS, {27'h0, hms[m], modes[m]});
      track(hms[m]);
    end
    print_verdict();
  end
endmodule // display_bridge_host_pin_mux_tb

`default_nettype wire
